// ### rtl/port_pin_edge_irq_regs.sv
// Port edge interrupt and narrow port pad control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "port_edge_regs.svh"

module port_pin_edge_irq_regs
    import port_edge_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire axil_req_s   axil_req_i,
    output var  axil_rsp_s   axil_rsp_o,
    input  wire byte_t       wide_pin_i,
    input  wire pair_t       narrow_pin_i,
    output var  wide_pad_s   wide_pad_o,
    output var  narrow_pad_s narrow_pad_o,
    output var  logic        irq_o
);

    // ****************************************
    // Declarations
    // ****************************************
    byte_t       wide_direction;
    byte_t       wide_pull_enable;
    byte_t       wide_port_polarity_select;
    byte_t       wide_port_irq_enable;
    byte_t       wide_port_irq_flag;
    pair_t       narrow_port_data;
    pair_t       narrow_port_direction;
    pair_t       narrow_port_drive_strength;
    pair_t       narrow_port_pull_enable;
    pair_t       narrow_polarity;

    byte_t       wide_meta;
    byte_t       wide_sync;
    byte_t       wide_prev;
    pair_t       narrow_meta;
    pair_t       narrow_sync;

    byte_t       wide_rise;
    byte_t       wide_fall;
    byte_t       wide_edge;
    byte_t       flag_clear;

    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic [5:0]  wr_idx;
    logic        wr_lane;
    byte_t       wr_byte;
    logic        rd_fire;
    logic [5:0]  rd_idx;

    logic        aw_take;
    logic        w_take;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;

    byte_t       next_rdata;
    byte_t       narrow_read;
    byte_t       narrow_pins;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [5:0] addr_index(input logic [7:0] addr);
        addr_index = addr[`ADDR_IDX_HI:`ADDR_IDX_LO];
    endfunction

    function automatic logic is_mapped(input logic [5:0] idx);
        unique case (idx)
            `IDX_WIDE_DIRECTION,
            `IDX_WIDE_PULL_ENABLE,
            `IDX_WIDE_POLARITY,
            `IDX_WIDE_IRQ_ENABLE,
            `IDX_WIDE_IRQ_FLAG,
            `IDX_NARROW_DATA,
            `IDX_NARROW_PIN_INPUT,
            `IDX_NARROW_DIRECTION,
            `IDX_NARROW_DRIVE,
            `IDX_NARROW_PULL_ENABLE,
            `IDX_NARROW_POLARITY: is_mapped = 1'b1;
            default:              is_mapped = 1'b0;
        endcase
    endfunction

    function automatic byte_t place_pair(input pair_t p);
        place_pair = `RST_BYTE;
        place_pair[`NARROW_HI:`NARROW_LO] = p;
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wide_meta   <= `RST_BYTE;
            wide_sync   <= `RST_BYTE;
            wide_prev   <= `RST_BYTE;
            narrow_meta <= `RST_PAIR;
            narrow_sync <= `RST_PAIR;
        end else begin
            wide_meta   <= wide_pin_i;
            wide_sync   <= wide_meta;
            wide_prev   <= wide_sync;
            narrow_meta <= narrow_pin_i;
            narrow_sync <= narrow_meta;
        end
    end

    // ****************************************
    // Edge detection
    // ****************************************
    always_comb begin
        wide_rise = wide_sync & ~wide_prev;
        wide_fall = ~wide_sync & wide_prev;
        // Polarity picks which edge counts
        wide_edge = (wide_port_polarity_select & wide_rise)
                  | (~wide_port_polarity_select & wide_fall);
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    // A channel is taken only while its ready stands high
    assign aw_take = axil_req_i.awvalid && awready;
    assign w_take  = axil_req_i.wvalid && wready;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_idx  = addr_index(aw_addr);
    assign wr_lane = w_strb[0];
    assign wr_byte = w_data[7:0];

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            aw_held <= 1'b0;
            aw_addr <= `RST_BYTE;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= axil_req_i.awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            w_held <= 1'b0;
            w_data <= `RST_WORD;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= axil_req_i.wdata;
            w_strb <= axil_req_i.wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            // Ready drops at a take and returns once the held word is used
            awready <= !aw_held && !aw_take;
            wready  <= !w_held && !w_take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (axil_req_i.bready) begin
            // Next write waits until this response is taken
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wide_direction            <= `RST_BYTE;
            wide_pull_enable          <= `RST_BYTE;
            wide_port_polarity_select <= `RST_BYTE;
            wide_port_irq_enable      <= `RST_BYTE;
        end else if (wr_fire && wr_lane) begin
            unique case (wr_idx)
                `IDX_WIDE_DIRECTION:   wide_direction            <= wr_byte;
                `IDX_WIDE_PULL_ENABLE: wide_pull_enable          <= wr_byte;
                `IDX_WIDE_POLARITY:    wide_port_polarity_select <= wr_byte;
                `IDX_WIDE_IRQ_ENABLE:  wide_port_irq_enable      <= wr_byte;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            narrow_port_data           <= `RST_PAIR;
            narrow_port_direction      <= `RST_PAIR;
            narrow_port_drive_strength <= `RST_PAIR;
            narrow_port_pull_enable    <= `RST_PAIR;
            narrow_polarity            <= `RST_PAIR;
        end else if (wr_fire && wr_lane) begin
            // Pin input register has no storage, so writes to it drop here
            unique case (wr_idx)
                `IDX_NARROW_DATA:
                    narrow_port_data <= wr_byte[`NARROW_HI:`NARROW_LO];
                `IDX_NARROW_DIRECTION:
                    narrow_port_direction <= wr_byte[`NARROW_HI:`NARROW_LO];
                `IDX_NARROW_DRIVE:
                    narrow_port_drive_strength <= wr_byte[`NARROW_HI:`NARROW_LO];
                `IDX_NARROW_PULL_ENABLE:
                    narrow_port_pull_enable <= wr_byte[`NARROW_HI:`NARROW_LO];
                `IDX_NARROW_POLARITY:
                    narrow_polarity <= wr_byte[`NARROW_HI:`NARROW_LO];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Interrupt flags
    // ****************************************
    always_comb begin
        flag_clear = `RST_BYTE;
        if (wr_fire && wr_lane && wr_idx == `IDX_WIDE_IRQ_FLAG) begin
            flag_clear = wr_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wide_port_irq_flag <= `RST_BYTE;
        end else begin
            // A new edge wins over a clear in the same cycle
            wide_port_irq_flag <= (wide_port_irq_flag & ~flag_clear) | wide_edge;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(wide_port_irq_flag & wide_port_irq_enable);
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    assign rd_fire = axil_req_i.arvalid && arready;
    assign rd_idx  = addr_index(axil_req_i.araddr);

    always_comb begin
        narrow_pins = place_pair(narrow_sync);
        narrow_read = place_pair((narrow_port_direction & narrow_port_data)
                               | (~narrow_port_direction & narrow_sync));
    end

    always_comb begin
        next_rdata = `RST_BYTE;
        unique case (rd_idx)
            `IDX_WIDE_DIRECTION:     next_rdata = wide_direction;
            `IDX_WIDE_PULL_ENABLE:   next_rdata = wide_pull_enable;
            `IDX_WIDE_POLARITY:      next_rdata = wide_port_polarity_select;
            `IDX_WIDE_IRQ_ENABLE:    next_rdata = wide_port_irq_enable;
            `IDX_WIDE_IRQ_FLAG:      next_rdata = wide_port_irq_flag;
            `IDX_NARROW_DATA:        next_rdata = narrow_read;
            `IDX_NARROW_PIN_INPUT:   next_rdata = narrow_pins;
            `IDX_NARROW_DIRECTION:   next_rdata = place_pair(narrow_port_direction);
            `IDX_NARROW_DRIVE:       next_rdata = place_pair(narrow_port_drive_strength);
            `IDX_NARROW_PULL_ENABLE: next_rdata = place_pair(narrow_port_pull_enable);
            `IDX_NARROW_POLARITY:    next_rdata = place_pair(narrow_polarity);
            default:                 next_rdata = `RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= `RST_WORD;
            rresp   <= `RESP_OKAY;
        end else if (rd_fire) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, next_rdata};
            rresp   <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid) begin
            // Address stays refused until the data is taken
            if (axil_req_i.rready) begin
                rvalid <= 1'b0;
            end
        end else begin
            arready <= 1'b1;
        end
    end

    // ****************************************
    // Bus response outputs
    // ****************************************
    always_comb begin
        axil_rsp_o.awready = awready;
        axil_rsp_o.wready  = wready;
        axil_rsp_o.bvalid  = bvalid;
        axil_rsp_o.bresp   = bresp;
        axil_rsp_o.arready = arready;
        axil_rsp_o.rvalid  = rvalid;
        axil_rsp_o.rdata   = rdata;
        axil_rsp_o.rresp   = rresp;
    end

    // ****************************************
    // Pad control
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wide_pad_o <= '0;
        end else begin
            wide_pad_o.pull_up   <= wide_pull_enable & ~wide_direction
                                  & ~wide_port_polarity_select;
            wide_pad_o.pull_down <= wide_pull_enable & ~wide_direction
                                  & wide_port_polarity_select;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            narrow_pad_o.pin_out       <= `RST_PAIR;
            narrow_pad_o.pin_oe_b      <= ~`RST_PAIR;
            narrow_pad_o.reduced_drive <= `RST_PAIR;
            narrow_pad_o.pull_up       <= `RST_PAIR;
            narrow_pad_o.pull_down     <= `RST_PAIR;
        end else begin
            narrow_pad_o.pin_out       <= narrow_port_data;
            narrow_pad_o.pin_oe_b      <= ~narrow_port_direction;
            narrow_pad_o.reduced_drive <= narrow_port_drive_strength
                                        & narrow_port_direction;
            narrow_pad_o.pull_up       <= narrow_port_pull_enable & ~narrow_port_direction
                                        & ~narrow_polarity;
            narrow_pad_o.pull_down     <= narrow_port_pull_enable & ~narrow_port_direction
                                        & narrow_polarity;
        end
    end

endmodule

`default_nettype wire

// ### pkg/port_edge_regs.svh
// Register indices, field positions and reset values of the port block
`ifndef PORT_EDGE_REGS_SVH
`define PORT_EDGE_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_WIDE_DIRECTION      6'h1a
`define IDX_WIDE_PULL_ENABLE    6'h1c
`define IDX_WIDE_POLARITY       6'h1d
`define IDX_WIDE_IRQ_ENABLE     6'h1e
`define IDX_WIDE_IRQ_FLAG       6'h1f
`define IDX_NARROW_DATA         6'h28
`define IDX_NARROW_PIN_INPUT    6'h29
`define IDX_NARROW_DIRECTION    6'h2a
`define IDX_NARROW_DRIVE        6'h2b
`define IDX_NARROW_PULL_ENABLE  6'h2c
`define IDX_NARROW_POLARITY     6'h2d

// Address field holding the index
`define ADDR_IDX_HI             7
`define ADDR_IDX_LO             2

// Narrow port occupies bits 7:6 of its registers
`define NARROW_HI               7
`define NARROW_LO               6

// Reset values
`define RST_BYTE                8'h00
`define RST_PAIR                2'h0
`define RST_WORD                32'h0000_0000

// AXI responses
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// ### pkg/port_edge_pkg.sv
// Types shared by the port edge interrupt block
package port_edge_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [1:0] pair_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;

    typedef struct packed {
        byte_t pull_up;
        byte_t pull_down;
    } wide_pad_s;

    typedef struct packed {
        pair_t pin_out;
        pair_t pin_oe_b;
        pair_t reduced_drive;
        pair_t pull_up;
        pair_t pull_down;
    } narrow_pad_s;

endpackage

// ### tb/port_edge_chk.sv
// Port-level checks for the port edge interrupt block
`timescale 1ns/1ps
`default_nettype none

module port_edge_chk
    import port_edge_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire axil_req_s   axil_req_i,
    input wire axil_rsp_s   axil_rsp_o,
    input wire byte_t       wide_pin_i,
    input wire pair_t       narrow_pin_i,
    input wire wide_pad_s   wide_pad_o,
    input wire narrow_pad_s narrow_pad_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    logic aw_take;
    logic w_take;
    logic ar_take;

    assign aw_take = axil_req_i.awvalid && axil_rsp_o.awready;
    assign w_take  = axil_req_i.wvalid && axil_rsp_o.wready;
    assign ar_take = axil_req_i.arvalid && axil_rsp_o.arready;

    a_wide_pull_excl: assert property ((wide_pad_o.pull_up & wide_pad_o.pull_down) == 8'h00)
        else $error("wide pull up and down both on");
    a_narrow_pull_in: assert property (((narrow_pad_o.pull_up | narrow_pad_o.pull_down) & ~narrow_pad_o.pin_oe_b) == 2'h0)
        else $error("narrow pull on a driven pin");
    a_drive_out_only: assert property ((narrow_pad_o.reduced_drive & narrow_pad_o.pin_oe_b) == 2'h0)
        else $error("reduced drive on an input pin");
    a_irq_fall_write: assert property ($fell(irq_o) |-> axil_rsp_o.bvalid || $past(axil_rsp_o.bvalid))
        else $error("interrupt dropped without a register write");
    a_bvalid_holds: assert property (axil_rsp_o.bvalid && !axil_req_i.bready |=> axil_rsp_o.bvalid)
        else $error("write response withdrawn");
    a_rvalid_holds: assert property (axil_rsp_o.rvalid && !axil_req_i.rready |=> $stable(axil_rsp_o.rdata) && axil_rsp_o.rvalid)
        else $error("read data withdrawn or changed");
    a_read_answer: assert property (ar_take |=> axil_rsp_o.rvalid && !axil_rsp_o.arready)
        else $error("read not answered next cycle");
    a_write_answer: assert property (aw_take && w_take |-> ##[1:3] axil_rsp_o.bvalid)
        else $error("write not answered in time");

    c_irq: cover property ($rose(irq_o));
    c_read: cover property (ar_take);
    c_write: cover property (aw_take && w_take);
endmodule

bind port_pin_edge_irq_regs port_edge_chk chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .axil_req_i(axil_req_i),
    .axil_rsp_o(axil_rsp_o), .wide_pin_i(wide_pin_i), .narrow_pin_i(narrow_pin_i), .wide_pad_o(wide_pad_o),
    .narrow_pad_o(narrow_pad_o), .irq_o(irq_o));
`default_nettype wire

// ### tb/pin_board.sv
// Board model resolving the narrow port pins from pad drive and pulls
`timescale 1ns/1ps
`default_nettype none

module pin_board
    import port_edge_pkg::*;
(
    input  wire logic        clk_i,
    input  wire narrow_pad_s narrow_pad_i,
    output var  pair_t       narrow_pin_o
);
    logic float_q = 1'b0;

    // Undriven pin wanders every cycle
    always_ff @(posedge clk_i) float_q <= ~float_q;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!narrow_pad_i.pin_oe_b[i]) narrow_pin_o[i] = narrow_pad_i.pin_out[i];
            else if (narrow_pad_i.pull_up[i]) narrow_pin_o[i] = 1'b1;
            else if (narrow_pad_i.pull_down[i]) narrow_pin_o[i] = 1'b0;
            else narrow_pin_o[i] = float_q ^ i[0];
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the port edge interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "port_edge_regs.svh"

module tb
    import port_edge_pkg::*;
;
    logic        clk_i;
    logic        rst_b_i;
    axil_req_s   req;
    axil_rsp_s   rsp;
    byte_t       wide;
    pair_t       narrow;
    wide_pad_s   wpad;
    narrow_pad_s npad;
    logic        irq;
    int          errors = 0;
    int          n_checks = 0;
    logic [33:0] rq[$];
    logic [1:0]  wq[$];
    logic [33:0] e;
    byte_t       pol, m, pe, d;
    byte_t       rst_regs[9] = '{8'h68, 8'h70, 8'h74, 8'h78, 8'h7c, 8'ha8, 8'hac, 8'hb0, 8'hb4};

    port_pin_edge_irq_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .axil_req_i(req), .axil_rsp_o(rsp),
        .wide_pin_i(wide), .narrow_pin_i(narrow), .wide_pad_o(wpad), .narrow_pad_o(npad), .irq_o(irq));
    pin_board board (.clk_i(clk_i), .narrow_pad_i(npad), .narrow_pin_o(narrow));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input byte_t a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
        logic aw, w;
        wq.push_back(er);
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        do begin
            @(posedge clk_i);
            if (aw && rsp.awready) begin
                aw = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready) begin
                w = 1'b0;
                req.wvalid <= 1'b0;
            end
        end while (!(rsp.bvalid && !aw && !w));
    endtask

    task automatic rd(input byte_t a, input logic [31:0] v, input logic [1:0] er);
        rq.push_back({er, v});
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do @(posedge clk_i); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge clk_i); while (!rsp.rvalid);
    endtask

    always @(posedge clk_i) begin
        if (rsp.rvalid && req.rready && rq.size() > 0) begin
            e = rq.pop_front();
            check("rdata", rsp.rdata, e[31:0]);
            check("rresp", 32'(rsp.rresp), 32'(e[33:32]));
        end
        if (rsp.bvalid && req.bready && wq.size() > 0) check("bresp", 32'(rsp.bresp), 32'(wq.pop_front()));
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        conclude();
    end

    initial begin
        void'($urandom(14));
        pol = 8'($urandom());
        m = 8'($urandom()) | 8'h01;
        pe = 8'($urandom());
        d = 8'($urandom());
        req <= '{bready: 1'b1, rready: 1'b1, default: '0};
        wide <= ~pol;
        rst_b_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        foreach (rst_regs[i]) rd(rst_regs[i], 32'h0000_0000, `RESP_OKAY);
        // Edge flags: active edges, then inactive return edges
        wr(8'h74, {24'h0, pol}, 4'hf, `RESP_OKAY);
        wide <= wide ^ m;
        repeat (5) @(posedge clk_i);
        wide <= wide ^ m;
        repeat (5) @(posedge clk_i);
        rd(8'h7c, {24'h0, m}, `RESP_OKAY);
        check("irq", 32'(irq), 32'h0000_0000);
        wr(8'h78, 32'h0000_00ff, 4'hf, `RESP_OKAY);
        // Interrupt output trails the enable by one register
        @(posedge clk_i);
        check("irq", 32'(irq), 32'h0000_0001);
        wr(8'h7c, 32'h0000_0000, 4'hf, `RESP_OKAY);
        rd(8'h7c, {24'h0, m}, `RESP_OKAY);
        wr(8'h7c, {24'h0, m & 8'hfe}, 4'hf, `RESP_OKAY);
        wr(8'h7c, 32'h0000_0001, 4'h0, `RESP_OKAY);
        rd(8'h7c, 32'h0000_0001, `RESP_OKAY);
        check("irq", 32'(irq), 32'h0000_0001);
        wr(8'h78, 32'h0000_00fe, 4'hf, `RESP_OKAY);
        @(posedge clk_i);
        check("irq", 32'(irq), 32'h0000_0000);
        wr(8'h7c, 32'h0000_0001, 4'hf, `RESP_OKAY);
        rd(8'h7c, 32'h0000_0000, `RESP_OKAY);
        // Wide pulls
        wr(8'h70, {24'h0, pe}, 4'hf, `RESP_OKAY);
        wr(8'h68, {24'h0, d}, 4'hf, `RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check("pull_up", 32'(wpad.pull_up), 32'(pe & ~pol & ~d));
        check("pull_down", 32'(wpad.pull_down), 32'(pe & pol & ~d));
        // Narrow port
        wr(8'hb0, 32'h0000_00c0, 4'hf, `RESP_OKAY);
        wr(8'hb4, 32'h0000_0040, 4'hf, `RESP_OKAY);
        // Pin readback trails the pads by the synchroniser
        repeat (3) @(posedge clk_i);
        rd(8'ha0, 32'h0000_0080, `RESP_OKAY);
        check("n_up", 32'(npad.pull_up), 32'h0000_0002);
        check("n_down", 32'(npad.pull_down), 32'h0000_0001);
        wr(8'ha0, 32'h0000_0040, 4'hf, `RESP_OKAY);
        wr(8'hac, 32'h0000_00c0, 4'hf, `RESP_OKAY);
        wr(8'ha8, 32'h0000_0040, 4'hf, `RESP_OKAY);
        repeat (3) @(posedge clk_i);
        check("oe_b", 32'(npad.pin_oe_b), 32'h0000_0002);
        check("pin_out", 32'(npad.pin_out[0]), 32'h0000_0001);
        check("drive", 32'(npad.reduced_drive), 32'h0000_0001);
        check("n_down", 32'(npad.pull_down), 32'h0000_0000);
        rd(8'ha0, 32'h0000_00c0, `RESP_OKAY);
        wr(8'ha4, 32'h0000_0000, 4'hf, `RESP_OKAY);
        rd(8'ha4, 32'h0000_00c0, `RESP_OKAY);
        rd(8'h00, 32'h0000_0000, `RESP_SLVERR);
        wr(8'h04, 32'h0000_0001, 4'hf, `RESP_SLVERR);
        conclude();
    end
endmodule
`default_nettype wire
